/* File: sip_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the ingress policy group.
// Assumes: 50 MHz switch clock; register index times four is the AXI byte address.
// Notes: Definitions only.
`ifndef SIP_CFG_SVH
`define SIP_CFG_SVH

`define SIP_IDX_MIRROR 14'h1846
`define SIP_IDX_TAGTYPE 14'h1847
`define SIP_IDX_THROTTLE 14'h1848
`define SIP_IDX_ADMIT 14'h1849
`define SIP_IDX_METER 14'h184a

`define SIP_MASK_MIRROR 32'h000001ff
`define SIP_MASK_TAGTYPE 32'h0000003f
`define SIP_MASK_THROTTLE 32'h07ffffff
`define SIP_MASK_ADMIT 32'h00000007
`define SIP_MASK_METER 32'h00000007

`define SIP_RST_MIRROR 32'h00000000
`define SIP_RST_TAGTYPE 32'h00000000
`define SIP_RST_THROTTLE 32'h00080402
`define SIP_RST_ADMIT 32'h00000000
`define SIP_RST_METER 32'h00000000

`define SIP_MIR_TX_BIT 0
`define SIP_MIR_RX_BIT 1
`define SIP_MIR_PORT_LSB 2
`define SIP_MIR_SNIF_LSB 5
`define SIP_MIR_FILT_BIT 8
`define SIP_THR_FIELD_STRIDE 9
`define SIP_THR_EN_OFS 8
`define SIP_MTR_EN_BIT 0
`define SIP_MTR_MODE_LSB 1
`define SIP_THR_UNIT_BYTES 64
`define SIP_ENTRIES_PER_PORT 8

`define SIP_CLK_PERIOD_NS 20
`define SIP_BCAST_INTERVAL_NS 1720000
`define SIP_BCAST_INTERVAL_CYCLES (`SIP_BCAST_INTERVAL_NS / `SIP_CLK_PERIOD_NS)

`define SIP_RESP_OKAY 2'h0
`define SIP_RESP_SLVERR 2'h2

`endif

/* File: sip_pkg.sv */
// Purpose: Shared types of the ingress policy register group.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Numeric constants live in sip_cfg.svh.
package sip_pkg;
  typedef enum logic [1:0] {
    SIP_MODE_PORT_PRI = 2'h0,
    SIP_MODE_PORT = 2'h1,
    SIP_MODE_PRI = 2'h2,
    SIP_MODE_RSVD = 2'h3
  } sip_meter_mode_t;

  typedef enum logic [2:0] {
    SIP_WR_IDLE = 3'h1,
    SIP_WR_COMMIT = 3'h2,
    SIP_WR_RESP = 3'h4
  } sip_wr_state_t;
endpackage : sip_pkg

/* File: sip_bcast_throttle.sv */
// Purpose: Broadcast byte budget of one port over a fixed interval.
// Assumes: tick pulses once per interval; frames arrive one per cycle at most.
// Notes: Budget is level times the unit size; a frame that would overrun it is rejected.
`include "sip_cfg.svh"
`timescale 1ns/1ps
module sip_bcast_throttle #(
  parameter int LEN_W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic [7:0] level,
  input wire logic frameValid,
  input wire logic [LEN_W-1:0] frameLen,
  output logic accept,
  output logic reject
);
  import sip_pkg::*;

  logic [15:0] usedBytes;
  wire [15:0] baseBytes = tick ? 16'h0000 : usedBytes;
  wire [15:0] sumBytes = baseBytes + 16'(frameLen);
  wire [15:0] budget = 16'(level) * 16'(`SIP_THR_UNIT_BYTES);
  wire fits = !enable || (sumBytes <= budget);

  // A tick in the same cycle as a frame opens the new interval first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usedBytes <= 16'h0000;
      accept <= 1'b0;
      reject <= 1'b0;
    end else begin
      accept <= frameValid && fits;
      reject <= frameValid && !fits;
      if (frameValid && fits) begin
        usedBytes <= sumBytes;
      end else begin
        usedBytes <= baseBytes;
      end
    end
  end
endmodule : sip_bcast_throttle

/* File: sip_policy_regs.sv */
// Purpose: Ingress and forwarding policy registers of the three-port switch engine.
// Assumes: AXI4-Lite slave on clk; datapath events are synchronous to clk.
// Notes: Decisions for the datapath are registered one cycle after the event.
//
// Implementation choice: the AXI4-Lite register port.
`include "sip_cfg.svh"
`timescale 1ns/1ps
module sip_policy_regs #(
  parameter int ADDR_W = 16,
  parameter int LEN_W = 11,
  parameter int INTERVAL_CYCLES = `SIP_BCAST_INTERVAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxPktValid,
  input wire logic [1:0] rxPktPort,
  input wire logic rxPktFiltered,
  output logic [2:0] rxDestMask,
  output logic [2:0] rxMirrorMask,
  output logic rxFilteredCount,
  output logic rxDropEvent,
  input wire logic txPktValid,
  input wire logic [1:0] txPktPort,
  output logic [2:0] txMirrorMask,
  output logic [2:0] tagDestEnable,
  input wire logic [2:0] bcastValid,
  input wire logic [3*LEN_W-1:0] bcastLen,
  output logic [2:0] bcastAccept,
  output logic [2:0] bcastReject,
  input wire logic vlanCheckValid,
  input wire logic [1:0] vlanCheckPort,
  input wire logic vlanPortMember,
  input wire logic vlanActive,
  output logic vlanAdmit,
  output logic vlanReject,
  input wire logic meterReqValid,
  input wire logic [1:0] meterReqPort,
  input wire logic [2:0] meterReqPri,
  output logic meterLookupValid,
  output logic [4:0] committedRateEntry,
  output logic meterEnable,
  output sip_pkg::sip_meter_mode_t meterMode
);
  import sip_pkg::*;

  logic [31:0] mirrorControl;
  logic [31:0] ingressTagDestType;
  logic [31:0] broadcastThrottle;
  logic [31:0] vlanNonmemberAdmit;
  logic [31:0] ingressMeterConfig;
  sip_wr_state_t wrState;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic awHeld;
  logic wHeld;
  logic [16:0] intervalCount;
  logic intervalTick;

  // Printed offsets are register indices, so the byte address is four times the index.
  wire [13:0] wrIndex = 14'(awAddrQ >> 2);
  wire [13:0] rdIndex = 14'(s_axi_araddr >> 2);
  wire wrAligned = awAddrQ[1:0] == 2'h0;
  wire rdAligned = s_axi_araddr[1:0] == 2'h0;
  wire wrHitMirror = wrAligned && (wrIndex == `SIP_IDX_MIRROR);
  wire wrHitTag = wrAligned && (wrIndex == `SIP_IDX_TAGTYPE);
  wire wrHitThrottle = wrAligned && (wrIndex == `SIP_IDX_THROTTLE);
  wire wrHitAdmit = wrAligned && (wrIndex == `SIP_IDX_ADMIT);
  wire wrHitMeter = wrAligned && (wrIndex == `SIP_IDX_METER);
  wire wrHitAny = wrHitMirror || wrHitTag || wrHitThrottle || wrHitAdmit || wrHitMeter;
  wire rdHitMirror = rdAligned && (rdIndex == `SIP_IDX_MIRROR);
  wire rdHitTag = rdAligned && (rdIndex == `SIP_IDX_TAGTYPE);
  wire rdHitThrottle = rdAligned && (rdIndex == `SIP_IDX_THROTTLE);
  wire rdHitAdmit = rdAligned && (rdIndex == `SIP_IDX_ADMIT);
  wire rdHitMeter = rdAligned && (rdIndex == `SIP_IDX_METER);
  wire rdHitAny = rdHitMirror || rdHitTag || rdHitThrottle || rdHitAdmit || rdHitMeter;

  wire [31:0] strbMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
  wire [31:0] next_mirrorControl =
    ((mirrorControl & ~strbMask) | (wDataQ & strbMask)) & `SIP_MASK_MIRROR;
  wire [31:0] next_ingressTagDestType =
    ((ingressTagDestType & ~strbMask) | (wDataQ & strbMask)) & `SIP_MASK_TAGTYPE;
  wire [31:0] next_broadcastThrottle =
    ((broadcastThrottle & ~strbMask) | (wDataQ & strbMask)) & `SIP_MASK_THROTTLE;
  wire [31:0] next_vlanNonmemberAdmit =
    ((vlanNonmemberAdmit & ~strbMask) | (wDataQ & strbMask)) & `SIP_MASK_ADMIT;
  wire [31:0] next_ingressMeterConfig =
    ((ingressMeterConfig & ~strbMask) | (wDataQ & strbMask)) & `SIP_MASK_METER;

  wire [31:0] rdMux =
    ({32{rdHitMirror}} & mirrorControl) |
    ({32{rdHitTag}} & ingressTagDestType) |
    ({32{rdHitThrottle}} & broadcastThrottle) |
    ({32{rdHitAdmit}} & vlanNonmemberAdmit) |
    ({32{rdHitMeter}} & ingressMeterConfig);

  wire wrCommit = wrState == SIP_WR_COMMIT;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rTake = s_axi_rvalid && s_axi_rready;
  // Address and data may be taken in the same cycle, so a take counts as already held.
  wire wrBothIn = (awHeld || awTake) && (wHeld || wTake);
  wire [1:0] wrResp = wrHitAny ? `SIP_RESP_OKAY : `SIP_RESP_SLVERR;
  wire [1:0] rdResp = rdHitAny ? `SIP_RESP_OKAY : `SIP_RESP_SLVERR;
  wire wrMirror = wrCommit && wrHitMirror;
  wire wrTag = wrCommit && wrHitTag;
  wire wrThrottle = wrCommit && wrHitThrottle;
  wire wrAdmit = wrCommit && wrHitAdmit;
  wire wrMeter = wrCommit && wrHitMeter;

  // Address and data are taken in either order; the response waits for both.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrState <= SIP_WR_IDLE;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIP_RESP_OKAY;
    end else begin
      case (wrState)
        SIP_WR_IDLE: begin
          if (awTake) begin
            awAddrQ <= s_axi_awaddr;
            awHeld <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (wTake) begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
            wHeld <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if (wrBothIn) begin
            wrState <= SIP_WR_COMMIT;
          end
        end
        SIP_WR_COMMIT: begin
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wrResp;
          wrState <= SIP_WR_RESP;
        end
        SIP_WR_RESP: begin
          // Readies stay low until the response is taken, so only one write is in flight.
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wrState <= SIP_WR_IDLE;
          end
        end
        default: begin
          wrState <= SIP_WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mirrorControl <= `SIP_RST_MIRROR;
      ingressTagDestType <= `SIP_RST_TAGTYPE;
      broadcastThrottle <= `SIP_RST_THROTTLE;
      vlanNonmemberAdmit <= `SIP_RST_ADMIT;
      ingressMeterConfig <= `SIP_RST_METER;
    end else begin
      if (wrMirror) mirrorControl <= next_mirrorControl;
      if (wrTag) ingressTagDestType <= next_ingressTagDestType;
      if (wrThrottle) broadcastThrottle <= next_broadcastThrottle;
      if (wrAdmit) vlanNonmemberAdmit <= next_vlanNonmemberAdmit;
      if (wrMeter) ingressMeterConfig <= next_ingressMeterConfig;
    end
  end

  // Reads answer one cycle after the address is taken; unmapped reads give zero.
  // A read may overlap a write; the two paths share nothing but the registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SIP_RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdResp;
    end else if (rTake) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Mirroring fields.
  wire mirTxEn = mirrorControl[`SIP_MIR_TX_BIT];
  wire mirRxEn = mirrorControl[`SIP_MIR_RX_BIT];
  wire mirFiltEn = mirrorControl[`SIP_MIR_FILT_BIT];
  wire [2:0] mirroredPorts = mirrorControl[`SIP_MIR_PORT_LSB +: 3];
  wire [2:0] snifferPorts = mirrorControl[`SIP_MIR_SNIF_LSB +: 3];
  wire [3:0] rxPortOneHot = 4'h1 << rxPktPort;
  wire [3:0] txPortOneHot = 4'h1 << txPktPort;
  wire rxOnMirrored = |(rxPortOneHot[2:0] & mirroredPorts);
  wire txOnMirrored = |(txPortOneHot[2:0] & mirroredPorts);
  // Several sniffer bits set copy to each of them; software is expected to avoid that.
  wire rxMirrorHit = mirRxEn && rxOnMirrored && (!rxPktFiltered || mirFiltEn);
  wire [2:0] next_rxMirrorMask = rxMirrorHit ? snifferPorts : 3'h0;
  // A filtered packet never reaches a normal destination, mirrored or not.
  wire [2:0] next_rxDestMask = rxPktFiltered ? 3'h0 : ~rxPortOneHot[2:0];
  wire [2:0] next_txMirrorMask = (mirTxEn && txOnMirrored) ? snifferPorts : 3'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxDestMask <= 3'h0;
      rxMirrorMask <= 3'h0;
      rxFilteredCount <= 1'b0;
      rxDropEvent <= 1'b0;
      txMirrorMask <= 3'h0;
    end else begin
      rxDestMask <= rxPktValid ? next_rxDestMask : 3'h0;
      rxMirrorMask <= rxPktValid ? next_rxMirrorMask : 3'h0;
      rxFilteredCount <= rxPktValid && rxPktFiltered;
      rxDropEvent <= rxPktValid && rxPktFiltered;
      txMirrorMask <= txPktValid ? next_txMirrorMask : 3'h0;
    end
  end

  // Per-port decode of type and throttle fields.
  // Each port keeps its own byte budget; only the interval tick is shared.
  logic [2:0] next_tagDestEnable;
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      assign next_tagDestEnable[p] = ingressTagDestType[2*p +: 2] == 2'h3;
      sip_bcast_throttle #(
        .LEN_W(LEN_W)
      ) u_throttle (
        .clk(clk),
        .rst_n(rst_n),
        .tick(intervalTick),
        .enable(broadcastThrottle[p*`SIP_THR_FIELD_STRIDE + `SIP_THR_EN_OFS]),
        .level(broadcastThrottle[p*`SIP_THR_FIELD_STRIDE +: 8]),
        .frameValid(bcastValid[p]),
        .frameLen(bcastLen[p*LEN_W +: LEN_W]),
        .accept(bcastAccept[p]),
        .reject(bcastReject[p])
      );
    end
  endgenerate

  // The interval divider runs freely; a long count because the interval is milliseconds.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intervalCount <= 17'h00000;
      intervalTick <= 1'b0;
    end else if (intervalCount == 17'(INTERVAL_CYCLES - 1)) begin
      intervalCount <= 17'h00000;
      intervalTick <= 1'b1;
    end else begin
      intervalCount <= intervalCount + 17'h00001;
      intervalTick <= 1'b0;
    end
  end

  // Non-member admission.
  // An inactive VLAN refuses every packet, member or not.
  wire [3:0] vlanPortOneHot = 4'h1 << vlanCheckPort;
  wire admitBit = |(vlanPortOneHot[2:0] & vlanNonmemberAdmit[2:0]);
  wire next_vlanAdmit = vlanActive && (vlanPortMember || admitBit);

  // Meter entry selection.
  // Reserved mode 11 selects entry 0 so that a stray setting cannot index past the table.
  wire [1:0] modeBits = ingressMeterConfig[`SIP_MTR_MODE_LSB +: 2];
  wire [4:0] entryPortPri = 5'(meterReqPort * `SIP_ENTRIES_PER_PORT) + 5'(meterReqPri);
  wire [4:0] entryPort = 5'(meterReqPort);
  wire [4:0] entryPri = 5'(meterReqPri);
  wire [4:0] next_entry =
    (modeBits == SIP_MODE_PORT_PRI) ? entryPortPri :
    (modeBits == SIP_MODE_PORT) ? entryPort :
    (modeBits == SIP_MODE_PRI) ? entryPri : 5'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tagDestEnable <= 3'h0;
      vlanAdmit <= 1'b0;
      vlanReject <= 1'b0;
      meterLookupValid <= 1'b0;
      committedRateEntry <= 5'h00;
      meterEnable <= 1'b0;
      meterMode <= SIP_MODE_PORT_PRI;
    end else begin
      // Configuration outputs lag their register by one cycle so that each leaves a flop.
      tagDestEnable <= next_tagDestEnable;
      vlanAdmit <= vlanCheckValid && next_vlanAdmit;
      vlanReject <= vlanCheckValid && !next_vlanAdmit;
      meterEnable <= ingressMeterConfig[`SIP_MTR_EN_BIT];
      meterMode <= sip_meter_mode_t'(modeBits);
      meterLookupValid <= meterReqValid && ingressMeterConfig[`SIP_MTR_EN_BIT];
      committedRateEntry <= meterReqValid ? next_entry : committedRateEntry;
    end
  end
endmodule : sip_policy_regs

/* File: sip_policy_monitor.sv */
// Purpose: Port-level checks of the ingress policy register group.
// Assumes: Bound to sip_policy_regs; one clock domain, async active-low reset.
// Notes: Checked datapath answers are sampled exactly one cycle after the request; broadcast verdicts are checked on port 0 only.
`timescale 1ns/1ps
module sip_policy_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rxPktValid,
  input wire logic [1:0] rxPktPort,
  input wire logic rxPktFiltered,
  input wire logic [2:0] rxDestMask,
  input wire logic [2:0] rxMirrorMask,
  input wire logic rxFilteredCount,
  input wire logic rxDropEvent,
  input wire logic txPktValid,
  input wire logic [2:0] txMirrorMask,
  input wire logic [2:0] bcastValid,
  input wire logic [2:0] bcastAccept,
  input wire logic [2:0] bcastReject,
  input wire logic vlanCheckValid,
  input wire logic vlanPortMember,
  input wire logic vlanActive,
  input wire logic vlanAdmit,
  input wire logic vlanReject,
  input wire logic meterReqValid,
  input wire logic [1:0] meterReqPort,
  input wire logic [2:0] meterReqPri,
  input wire logic meterLookupValid,
  input wire logic [4:0] committedRateEntry,
  input wire logic meterEnable,
  input wire sip_pkg::sip_meter_mode_t meterMode
);
  import sip_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sFiltReq;
    rxPktValid && rxPktFiltered;
  endsequence
  sequence sFiltOut;
    rxDestMask == 3'h0 && rxFilteredCount && rxDropEvent;
  endsequence

  AST_RX_FILT: assert property (sFiltReq |=> sFiltOut)
    else $error("Dropped packet forwarded or not counted");
  AST_RX_FWD: assert property (rxPktValid && !rxPktFiltered |=>
    rxDestMask == (3'h7 & ~(3'h1 << $past(rxPktPort))) && !rxFilteredCount && !rxDropEvent)
    else $error("Accepted packet has wrong destinations or counts as dropped");
  AST_RX_QUIET: assert property (!rxPktValid |=> rxMirrorMask == 3'h0)
    else $error("Receive mirror copy without a packet");
  AST_TX_QUIET: assert property (!txPktValid |=> txMirrorMask == 3'h0)
    else $error("Transmit mirror copy without a packet");
  AST_VLAN_INACT: assert property (vlanCheckValid && !vlanActive |=> vlanReject && !vlanAdmit)
    else $error("Packet for an inactive VLAN admitted");
  AST_VLAN_MEMBER: assert property (vlanCheckValid && vlanActive && vlanPortMember |=>
    vlanAdmit && !vlanReject)
    else $error("Member packet on an active VLAN refused");
  AST_BCAST: assert property (bcastValid[0] |=> bcastAccept[0] ^ bcastReject[0])
    else $error("Broadcast frame not given exactly one verdict");
  AST_METER_OFF: assert property (meterReqValid && !meterEnable |=> !meterLookupValid)
    else $error("Meter lookup while metering is disabled");
  AST_METER_ENTRY: assert property (meterReqValid && meterEnable &&
    meterMode == SIP_MODE_PORT_PRI |=>
    meterLookupValid && committedRateEntry == {$past(meterReqPort), $past(meterReqPri)})
    else $error("Rate entry not grouped eight per port");
endmodule : sip_policy_monitor

/* File: sip_policy_tb.sv */
// Purpose: Self-checking bench for the ingress policy register group.
// Assumes: AXI4-Lite master in the bench; datapath requests as one-cycle pulses.
// Notes: The broadcast interval is shortened to 1000 cycles to keep the run brief.
`timescale 1ns/1ps
module testbench;
  import sip_pkg::*;
  localparam logic [15:0] regAddr [5] = '{16'h6118, 16'h611c, 16'h6120, 16'h6124, 16'h6128};
  localparam logic [31:0] regMask [5] = '{32'h1ff, 32'h3f, 32'h07ffffff, 32'h7, 32'h7};
  localparam logic [31:0] regRst [5] = '{32'h0, 32'h0, 32'h00080402, 32'h0, 32'h0};
  localparam logic [4:0] modeEntry [4] = '{5'h13, 5'h02, 5'h03, 5'h00};
  logic clk, rst_n;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rxPktPort, txPktPort, vlanCheckPort, meterReqPort;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rxPktValid, rxPktFiltered, rxFilteredCount, rxDropEvent, txPktValid;
  logic [2:0] rxDestMask, rxMirrorMask, txMirrorMask, tagDestEnable, meterReqPri;
  logic [2:0] bcastValid, bcastAccept, bcastReject;
  logic [32:0] bcastLen;
  logic vlanCheckValid, vlanPortMember, vlanActive, vlanAdmit, vlanReject;
  logic meterReqValid, meterLookupValid, meterEnable;
  logic [4:0] committedRateEntry;
  sip_meter_mode_t meterMode;
  int errCount, checkCount;

  sip_policy_regs #(.INTERVAL_CYCLES(1000)) dut (.*);

  task automatic reportAndStop();
    if (errCount == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : reportAndStop

  task automatic chk(input logic [31:0] have, input logic [31:0] want);
    checkCount++;
    if (have !== want) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, have, want);
    end
  endtask : chk

  // Readiness is sampled at the falling edge so the release lands right after the taking edge.
  task automatic axiWr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!tb && n < 50) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      if (tb) chk(32'(s_axi_bresp), 32'(resp));
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      n++;
    end
    if (!tb) begin
      errCount++;
      reportAndStop();
    end
  endtask : axiWr

  task automatic axiRd(input logic [15:0] a, input logic [31:0] want, input logic [1:0] resp);
    logic ta, tr;
    int n;
    tr = 1'b0;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!tr && n < 50) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      if (tr) chk(s_axi_rdata, want);
      if (tr) chk(32'(s_axi_rresp), 32'(resp));
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
    end
    if (!tr) begin
      errCount++;
      reportAndStop();
    end
  endtask : axiRd

  task automatic rxPkt(input logic [1:0] p, input logic f, input logic [2:0] dest,
                       input logic [2:0] mir);
    @(posedge clk);
    {rxPktValid, rxPktPort, rxPktFiltered} <= {1'b1, p, f};
    @(posedge clk);
    rxPktValid <= 1'b0;
    #1;
    chk(32'(rxDestMask), 32'(dest));
    chk(32'(rxMirrorMask), 32'(mir));
    chk(32'({rxFilteredCount, rxDropEvent}), 32'({f, f}));
  endtask : rxPkt

  task automatic txPkt(input logic [1:0] p, input logic [2:0] mir);
    @(posedge clk);
    {txPktValid, txPktPort} <= {1'b1, p};
    @(posedge clk);
    txPktValid <= 1'b0;
    #1;
    chk(32'(txMirrorMask), 32'(mir));
  endtask : txPkt

  task automatic bcFrame(input int p, input logic [10:0] len, input logic acc);
    @(posedge clk);
    bcastValid[p] <= 1'b1;
    bcastLen[p*11+:11] <= len;
    @(posedge clk);
    bcastValid[p] <= 1'b0;
    #1;
    chk(32'({bcastAccept[p], bcastReject[p]}), 32'({acc, !acc}));
  endtask : bcFrame

  task automatic vlanChk(input logic [1:0] p, input logic mem, input logic act, input logic ok);
    @(posedge clk);
    {vlanCheckValid, vlanCheckPort, vlanPortMember, vlanActive} <= {1'b1, p, mem, act};
    @(posedge clk);
    vlanCheckValid <= 1'b0;
    #1;
    chk(32'({vlanAdmit, vlanReject}), 32'({ok, !ok}));
  endtask : vlanChk

  task automatic meterReq(input logic [1:0] p, input logic [2:0] pri, input logic [4:0] ent,
                          input logic lv);
    @(posedge clk);
    {meterReqValid, meterReqPort, meterReqPri} <= {1'b1, p, pri};
    @(posedge clk);
    meterReqValid <= 1'b0;
    #1;
    chk(32'(meterLookupValid), 32'(lv));
    if (lv) chk(32'(committedRateEntry), 32'(ent));
  endtask : meterReq

  task automatic testRegs();
    for (int i = 0; i < 5; i++) begin
      axiRd(regAddr[i], regRst[i], 2'h0);
      axiWr(regAddr[i], 32'hffffffff, 2'h0);
      axiRd(regAddr[i], regMask[i], 2'h0);
      axiWr(regAddr[i], 32'h0, 2'h0);
      axiRd(regAddr[i], 32'h0, 2'h0);
    end
    axiWr(16'h6130, 32'h1, 2'h2);
    axiRd(16'h6130, 32'h0, 2'h2);
  endtask : testRegs

  task automatic testMirror();
    axiWr(regAddr[0], 32'h0000008f, 2'h0);
    rxPkt(2'h0, 1'b0, 3'h6, 3'h4);
    rxPkt(2'h2, 1'b0, 3'h3, 3'h0);
    rxPkt(2'h0, 1'b1, 3'h0, 3'h0);
    txPkt(2'h1, 3'h4);
    txPkt(2'h2, 3'h0);
    axiWr(regAddr[0], 32'h0000018e, 2'h0);
    rxPkt(2'h1, 1'b1, 3'h0, 3'h4);
    txPkt(2'h1, 3'h0);
    axiWr(regAddr[0], 32'h00000052, 2'h0);
    rxPkt(2'h2, 1'b0, 3'h3, 3'h2);
  endtask : testMirror

  task automatic testTagAndVlan();
    logic [5:0] tv [3] = '{6'h33, 6'h1e, 6'h24};
    logic [2:0] te [3] = '{3'h5, 3'h2, 3'h0};
    for (int i = 0; i < 3; i++) begin
      axiWr(regAddr[1], 32'(tv[i]), 2'h0);
      @(negedge clk);
      chk(32'(tagDestEnable), 32'(te[i]));
    end
    axiWr(regAddr[3], 32'h2, 2'h0);
    vlanChk(2'h1, 1'b0, 1'b1, 1'b1);
    vlanChk(2'h0, 1'b0, 1'b1, 1'b0);
    vlanChk(2'h1, 1'b0, 1'b0, 1'b0);
    vlanChk(2'h0, 1'b1, 1'b1, 1'b1);
  endtask : testTagAndVlan

  // Port 0 gets a budget of 64 bytes, port 2 keeps 128, port 1 is left unthrottled.
  task automatic testThrottle();
    axiWr(regAddr[2], 32'h04080501, 2'h0);
    bcFrame(0, 11'd64, 1'b1);
    bcFrame(0, 11'd1, 1'b0);
    bcFrame(1, 11'd2000, 1'b1);
    bcFrame(2, 11'd100, 1'b1);
    bcFrame(2, 11'd29, 1'b0);
    bcFrame(2, 11'd28, 1'b1);
    repeat (1010) @(posedge clk);
    bcFrame(0, 11'd64, 1'b1);
  endtask : testThrottle

  task automatic testMeter();
    for (int m = 0; m < 4; m++) begin
      axiWr(regAddr[4], 32'(m * 2 + 1), 2'h0);
      @(negedge clk);
      chk(32'(meterMode), 32'(m));
      chk(32'(meterEnable), 32'h1);
      meterReq(2'h2, 3'h3, modeEntry[m], 1'b1);
    end
    axiWr(regAddr[4], 32'h1, 2'h0);
    meterReq(2'h1, 3'h5, 5'h0d, 1'b1);
    axiWr(regAddr[4], 32'h0, 2'h0);
    @(negedge clk);
    chk(32'(meterEnable), 32'h0);
    meterReq(2'h1, 3'h5, 5'h0, 1'b0);
  endtask : testMeter

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    errCount = 0;
    checkCount = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {rxPktValid, rxPktPort, rxPktFiltered, txPktValid, txPktPort} = '0;
    {bcastValid, bcastLen, vlanCheckValid, vlanCheckPort, vlanPortMember, vlanActive} = '0;
    {meterReqValid, meterReqPort, meterReqPri} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    testRegs();
    testMirror();
    testTagAndVlan();
    testThrottle();
    testMeter();
    reportAndStop();
  end
endmodule : testbench

bind sip_policy_regs sip_policy_monitor mon (.*);
